// ### hw/spd_regs.sv
// Purpose: control and status register bank of a segment panel driver
// Assumes: APB slave, zero wait states; frame_event from same clock
// Notes:   operating clock is modelled as an enable tick off mclk
//
// Overview of operation
// - source select picks one of four clocks; unsupported sources cannot be chosen
// - fast sources divide 1/16..1/1024 by codes 0-6; slow sources need code 7
// - clock configuration accepts writes only while the module is disabled
// - without debug run the operating clock stops in debug mode
// - display off: discharge on drives pins low, otherwise pins float
// - module enable starts the operating clock; clears to stop; resets to 0
// - disabling while displaying turns display and regulator off
// - frame rate field bits 11-8 of timing one, reset 0x3
// - duty field bits 2-0 of timing one, reset 0x7
// - waveform select bit 15 of timing two: 1 waveform A, reset 0
// - booster clock is operating clock over 4, 16, 32 or 64; reset code 1
// - supply mode 1 external, 0 internal generation; resets to 1
// - divider resistor select: 0 unused, 1 smallest, 3 largest
// - contrast 0x00 lightest to 0x1f darkest, reset 0x00
// - booster on and regulator on bits, both reset to 0
// - bias select 1 third, 0 half, reset 1; heavy load protect bit
// - regulator output 1 second reference; software keeps 0 in external mode
// - segment and common order 1 normal, reset 1; common order kept for duty 4-6
// - inversion, display area and display mode fields
// - eight common partial drive bits, 1 normal, reset to 1
// - frame flag set by frame event while the module is enabled, cleared by writing 1; enable resets 0
// - interrupt request only while flag set and enable set
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module spd_regs
  import spd_pkg::*;
#(
  parameter logic [3:0] SRC_SUPPORTED = 4'hf,  // one bit per clock source
  parameter int         DIV_CNT_W     = 10     // operating clock divider width
)(
  input  wire logic        mclk,                     // 250 MHz system clock
  input  wire logic        srst,                     // synchronous reset
  input  wire logic        psel,                     // apb select
  input  wire logic        penable,                  // apb access phase
  input  wire logic        pwrite,                   // apb direction
  input  wire logic [7:0]  paddr,                    // apb byte address
  input  wire logic [31:0] pwdata,                   // apb write data
  output logic [31:0]      prdata,                   // apb read data
  output logic             pready,                   // apb ready
  output logic             pslverr,                  // apb error
  input  wire logic        debug_mode,               // cpu in debug, async
  input  wire logic        frame_event,              // frame switch pulse
  output logic [1:0]       source_select,            // operating clock source
  output logic [2:0]       divider_select,           // divider code
  output logic             op_tick,                  // operating clock tick
  output logic             boost_tick,               // booster clock tick
  output logic [3:0]       frame_rate_setting,       // frame frequency
  output logic [2:0]       drive_duty_select,        // duty
  output logic             waveform_select,          // 1 waveform a
  output logic [2:0]       inverse_line_count,       // n-line inversion
  output logic             supply_mode_select,       // 1 external supply
  output logic [1:0]       divider_resistor_select,  // resistor value
  output logic [4:0]       contrast_level,           // contrast
  output logic             booster_on,               // booster enable
  output logic             bias_select,              // 1 third bias
  output logic             heavy_load_protect,       // regulator mode
  output logic             regulator_output_select,  // reference select
  output logic             regulator_on,             // regulator enable
  output logic             segment_order,            // 1 normal order
  output logic             common_order,             // 1 normal order
  output logic             display_inversion,        // 1 normal display
  output logic             display_area_select,      // ram area
  output logic [1:0]       display_on_off_mode,      // on/off and mode
  output logic [7:0]       common_partial_drive,     // per common enable
  output logic             pin_drive_low,            // seg/com forced low
  output logic             pin_hiz,                  // seg/com released
  output logic             irq                       // frame interrupt
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (DIV_CNT_W < 10 || SRC_SUPPORTED == 4'h0)
  begin : g_chk
    $error("spd_regs: divider too narrow or no clock source");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        dbg_meta;
    logic        dbg_sync;
    logic [31:0] rdata;
    logic        debug_run;
    logic [2:0]  divider;
    logic [1:0]  source;
    logic        discharge;
    logic        enable;
    logic [3:0]  frame_rate;
    logic [2:0]  duty;
    logic        waveform;
    logic [1:0]  boost_clk;
    logic [2:0]  inv_lines;
    logic        supply_mode;
    logic [1:0]  resistor;
    logic [4:0]  contrast;
    logic        booster;
    logic        bias;
    logic        heavy_load;
    logic        reg_output;
    logic        reg_on;
    logic        seg_order;
    logic        com_order;
    logic        inversion;
    logic        area;
    logic [1:0]  disp_mode;
    logic [7:0]  com_drive;
    logic        frame_flag;
    logic        frame_ie;
  } spd_state_type;

  spd_state_type s_q;
  spd_state_type s_d;
  logic          wr_access;
  logic          rd_setup;
  logic          clk_run;
  logic [3:0]    op_shift;
  logic [3:0]    boost_shift;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // legal source and divider pairs
  function automatic logic clk_ok(input logic [1:0] src, input logic [2:0] div);
    logic slow;
    slow = (src == SRC_LOW_SPEED) || (src == SRC_EXTERNAL);
    clk_ok = SRC_SUPPORTED[src] && (slow ? (div == DIV_BYPASS) : (div != DIV_BYPASS));
  endfunction

  // address decode
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      OFS_CLOCK_CONFIG, OFS_MODULE_CTRL, OFS_TIMING_ONE, OFS_TIMING_TWO,
      OFS_POWER_CTRL, OFS_DISPLAY_CTRL, OFS_COMMON_DRIVE, OFS_IRQ_FLAGS,
      OFS_IRQ_ENABLES: is_mapped = 1'b1;
      default:         is_mapped = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // zero wait states keep the bus cost to one setup and one access
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !is_mapped(paddr);
  assign wr_access = psel && penable && pwrite && is_mapped(paddr);
  assign rd_setup  = psel && !penable && !pwrite;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d          = s_q;
    s_d.dbg_meta = debug_mode;
    s_d.dbg_sync = s_q.dbg_meta;

    // read data captured in setup, shown in access; reserved bits zero
    s_d.rdata = '0;
    if (rd_setup)
    begin
      case (paddr)
        OFS_CLOCK_CONFIG: s_d.rdata = {23'h0, s_q.debug_run, 1'b0, s_q.divider, 2'h0, s_q.source};
        OFS_MODULE_CTRL:  s_d.rdata = {30'h0, s_q.discharge, s_q.enable};
        OFS_TIMING_ONE:   s_d.rdata = {20'h0, s_q.frame_rate, 5'h0, s_q.duty};
        OFS_TIMING_TWO:   s_d.rdata = {16'h0, s_q.waveform, 5'h0, s_q.boost_clk, 5'h0, s_q.inv_lines};
        OFS_POWER_CTRL:   s_d.rdata = {16'h0, s_q.supply_mode, s_q.resistor, s_q.contrast, 3'h0,
                                       s_q.booster, s_q.bias, s_q.heavy_load, s_q.reg_output, s_q.reg_on};
        OFS_DISPLAY_CTRL: s_d.rdata = {25'h0, s_q.seg_order, s_q.com_order, s_q.inversion, 1'b0,
                                       s_q.area, s_q.disp_mode};
        OFS_COMMON_DRIVE: s_d.rdata = {24'h0, s_q.com_drive};
        OFS_IRQ_FLAGS:    s_d.rdata = {31'h0, s_q.frame_flag};
        OFS_IRQ_ENABLES:  s_d.rdata = {31'h0, s_q.frame_ie};
        default:          s_d.rdata = '0;
      endcase
    end

    if (wr_access)
    begin
      case (paddr)
        OFS_CLOCK_CONFIG:
        begin
          // locked while running; illegal pairs leave the old setting
          if (!s_q.enable && clk_ok(pwdata[POS_SOURCE +: 2], pwdata[POS_DIVIDER +: 3]))
          begin
            s_d.source    = pwdata[POS_SOURCE +: 2];
            s_d.divider   = pwdata[POS_DIVIDER +: 3];
            s_d.debug_run = pwdata[POS_DEBUG_RUN];
          end
        end
        OFS_MODULE_CTRL:
        begin
          s_d.discharge = pwdata[POS_DISCHARGE];
          s_d.enable    = pwdata[POS_ENABLE];
          if (s_q.enable && !pwdata[POS_ENABLE] && s_q.disp_mode != DISP_OFF)
          begin
            s_d.disp_mode = DISP_OFF;
            s_d.reg_on    = 1'b0;
          end
        end
        OFS_TIMING_ONE:
        begin
          s_d.frame_rate = pwdata[POS_FRAME_RATE +: 4];
          s_d.duty       = pwdata[POS_DUTY +: 3];
        end
        OFS_TIMING_TWO:
        begin
          s_d.waveform  = pwdata[POS_WAVEFORM];
          s_d.boost_clk = pwdata[POS_BOOST_CLK +: 2];
          s_d.inv_lines = pwdata[POS_INV_LINES +: 3];
        end
        OFS_POWER_CTRL:
        begin
          s_d.supply_mode = pwdata[POS_SUPPLY_MODE];
          s_d.resistor    = pwdata[POS_RESISTOR +: 2];
          s_d.contrast    = pwdata[POS_CONTRAST +: 5];
          s_d.booster     = pwdata[POS_BOOSTER_ON];
          s_d.bias        = pwdata[POS_BIAS];
          s_d.heavy_load  = pwdata[POS_HEAVY_LOAD];
          s_d.reg_output  = pwdata[POS_REG_OUTPUT];
          s_d.reg_on      = pwdata[POS_REG_ON];
        end
        OFS_DISPLAY_CTRL:
        begin
          s_d.seg_order = pwdata[POS_SEG_ORDER];
          s_d.com_order = pwdata[POS_COM_ORDER];
          s_d.inversion = pwdata[POS_INVERSION];
          s_d.area      = pwdata[POS_AREA];
          s_d.disp_mode = pwdata[POS_DISP_MODE +: 2];
        end
        OFS_COMMON_DRIVE: s_d.com_drive = pwdata[7:0];
        OFS_IRQ_FLAGS:
        begin
          if (pwdata[POS_FRAME_FLAG])
          begin
            s_d.frame_flag = 1'b0;
          end
        end
        OFS_IRQ_ENABLES:  s_d.frame_ie = pwdata[POS_FRAME_FLAG];
        default:          s_d.frame_ie = s_q.frame_ie;
      endcase
    end

    // event after the clear so a same-cycle frame is not lost
    if (frame_event && s_q.enable)
    begin
      s_d.frame_flag = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      s_q             <= '0;
      s_q.debug_run   <= RST_DEBUG_RUN;
      s_q.divider     <= RST_DIVIDER;
      s_q.source      <= RST_SOURCE;
      s_q.frame_rate  <= RST_FRAME_RATE;
      s_q.duty        <= RST_DUTY;
      s_q.boost_clk   <= RST_BOOST_CLK;
      s_q.supply_mode <= RST_SUPPLY_MODE;
      s_q.bias        <= RST_BIAS;
      s_q.seg_order   <= 1'b1;
      s_q.com_order   <= 1'b1;
      s_q.inversion   <= 1'b1;
      s_q.com_drive   <= RST_COM_DRIVE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // operating and booster clock ticks
  // ----------------------------------------------------------------
  // debug hold uses the synchronised level only
  assign clk_run     = s_q.enable && !(s_q.dbg_sync && !s_q.debug_run);
  assign op_shift    = (s_q.divider == DIV_BYPASS) ? 4'h0 : (DIV_BASE_LOG + {1'b0, s_q.divider});
  assign boost_shift = (s_q.boost_clk == 2'h0) ? 4'h2 : (4'h3 + {2'h0, s_q.boost_clk});

  spd_tick_div #(
    .CNT_W    (DIV_CNT_W)
  ) u_op_div (
    .mclk     (mclk),
    .srst     (srst),
    .en       (clk_run),
    .tick_in  (1'b1),
    .shift    (op_shift),
    .tick_out (op_tick)
  );

  spd_tick_div #(
    .CNT_W    (6)
  ) u_boost_div (
    .mclk     (mclk),
    .srst     (srst),
    .en       (s_q.enable),
    .tick_in  (op_tick),
    .shift    (boost_shift),
    .tick_out (boost_tick)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata                  = s_q.rdata;
  assign source_select           = s_q.source;
  assign divider_select          = s_q.divider;
  assign frame_rate_setting      = s_q.frame_rate;
  assign drive_duty_select       = s_q.duty;
  assign waveform_select         = s_q.waveform;
  assign inverse_line_count      = s_q.inv_lines;
  assign supply_mode_select      = s_q.supply_mode;
  assign divider_resistor_select = s_q.resistor;
  assign contrast_level          = s_q.contrast;
  assign booster_on              = s_q.booster;
  assign bias_select             = s_q.bias;
  assign heavy_load_protect      = s_q.heavy_load;
  assign regulator_output_select = s_q.reg_output;
  assign regulator_on            = s_q.reg_on;
  assign segment_order           = s_q.seg_order;
  assign common_order            = s_q.com_order;
  assign display_inversion       = s_q.inversion;
  assign display_area_select     = s_q.area;
  assign display_on_off_mode     = s_q.disp_mode;
  assign common_partial_drive    = s_q.com_drive;
  // display off state of the seg/com pins
  assign pin_drive_low           = (s_q.disp_mode == DISP_OFF) && s_q.discharge;
  assign pin_hiz                 = (s_q.disp_mode == DISP_OFF) && !s_q.discharge;
  assign irq                     = s_q.frame_flag && s_q.frame_ie;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_src_legal;
    @(posedge mclk) disable iff (srst) SRC_SUPPORTED[source_select] && clk_ok(source_select, divider_select);
  endproperty
  a_src_legal: assert property (p_src_legal) else $error("illegal clock source or divider");

  property p_clk_lock;
    @(posedge mclk) disable iff (srst) s_q.enable |=> $stable({s_q.source, s_q.divider, s_q.debug_run});
  endproperty
  a_clk_lock: assert property (p_clk_lock) else $error("clock config changed while enabled");

  property p_dbg_hold;
    @(posedge mclk) disable iff (srst) (s_q.dbg_sync && !s_q.debug_run) |=> !op_tick;
  endproperty
  a_dbg_hold: assert property (p_dbg_hold) else $error("operating tick during debug hold");

  property p_pins;
    @(posedge mclk) disable iff (srst)
      (display_on_off_mode == DISP_OFF) |-> (pin_drive_low != pin_hiz) && (pin_drive_low == s_q.discharge);
  endproperty
  a_pins: assert property (p_pins) else $error("pin state wrong in display off");

  property p_stop;
    @(posedge mclk) disable iff (srst) !s_q.enable |=> !op_tick;
  endproperty
  a_stop: assert property (p_stop) else $error("operating tick while disabled");

  property p_off_on_disable;
    @(posedge mclk) disable iff (srst)
      $fell(s_q.enable) && ($past(display_on_off_mode) != DISP_OFF) |-> (display_on_off_mode == DISP_OFF) && !regulator_on;
  endproperty
  a_off_on_disable: assert property (p_off_on_disable) else $error("display not off after disable");

  property p_boost_gap;
    @(posedge mclk) disable iff (srst) boost_tick |=> !boost_tick [*3];
  endproperty
  a_boost_gap: assert property (p_boost_gap) else $error("booster tick faster than quarter rate");

  property p_flag_set;
    @(posedge mclk) disable iff (srst) (frame_event && s_q.enable) |=> s_q.frame_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("frame flag not set");

  property p_irq;
    @(posedge mclk) disable iff (srst) (s_q.frame_flag && s_q.frame_ie) ##1 s_q.frame_ie |-> $past(irq);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing while flag and enable set");

  property p_resv;
    @(posedge mclk) disable iff (srst) (psel && penable && !pwrite) |-> (prdata[31:16] == 16'h0000);
  endproperty
  a_resv: assert property (p_resv) else $error("reserved read bits not zero");

endmodule
`default_nettype wire

// ### hw/spd_pkg.sv
// Purpose: shared constants for the segment panel driver register bank
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   registers are 16 bits wide; upper bus bits read as zero
package spd_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CLOCK_CONFIG = 8'h00;
  localparam logic [7:0] OFS_MODULE_CTRL  = 8'h04;
  localparam logic [7:0] OFS_TIMING_ONE   = 8'h08;
  localparam logic [7:0] OFS_TIMING_TWO   = 8'h0c;
  localparam logic [7:0] OFS_POWER_CTRL   = 8'h10;
  localparam logic [7:0] OFS_DISPLAY_CTRL = 8'h14;
  localparam logic [7:0] OFS_COMMON_DRIVE = 8'h18;
  localparam logic [7:0] OFS_IRQ_FLAGS    = 8'h1c;
  localparam logic [7:0] OFS_IRQ_ENABLES  = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_DEBUG_RUN   = 8;
  localparam int POS_DIVIDER     = 4;
  localparam int POS_SOURCE      = 0;
  localparam int POS_DISCHARGE   = 1;
  localparam int POS_ENABLE      = 0;
  localparam int POS_FRAME_RATE  = 8;
  localparam int POS_DUTY        = 0;
  localparam int POS_WAVEFORM    = 15;
  localparam int POS_BOOST_CLK   = 8;
  localparam int POS_INV_LINES   = 0;
  localparam int POS_SUPPLY_MODE = 15;
  localparam int POS_RESISTOR    = 13;
  localparam int POS_CONTRAST    = 8;
  localparam int POS_BOOSTER_ON  = 4;
  localparam int POS_BIAS        = 3;
  localparam int POS_HEAVY_LOAD  = 2;
  localparam int POS_REG_OUTPUT  = 1;
  localparam int POS_REG_ON      = 0;
  localparam int POS_SEG_ORDER   = 6;
  localparam int POS_COM_ORDER   = 5;
  localparam int POS_INVERSION   = 4;
  localparam int POS_AREA        = 2;
  localparam int POS_DISP_MODE   = 0;
  localparam int POS_FRAME_FLAG  = 0;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic       RST_DEBUG_RUN   = 1'b1;
  localparam logic [2:0] RST_DIVIDER     = 3'h0;
  localparam logic [1:0] RST_SOURCE      = 2'h0;
  localparam logic [3:0] RST_FRAME_RATE  = 4'h3;
  localparam logic [2:0] RST_DUTY        = 3'h7;
  localparam logic [1:0] RST_BOOST_CLK   = 2'h1;
  localparam logic       RST_SUPPLY_MODE = 1'b1;
  localparam logic       RST_BIAS        = 1'b1;
  localparam logic [7:0] RST_COM_DRIVE   = 8'hff;

  // ----------------------------------------------------------------
  // clock sources and divider codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_INTERNAL   = 2'b00,
    SRC_LOW_SPEED  = 2'b01,
    SRC_HIGH_SPEED = 2'b10,
    SRC_EXTERNAL   = 2'b11
  } spd_source_type;

  localparam logic [2:0] DIV_BYPASS   = 3'h7;  // 1/1, slow sources only
  localparam logic [3:0] DIV_BASE_LOG = 4'h4;  // code 0 divides by 16
  localparam logic [1:0] DISP_OFF     = 2'h0;

endpackage

// ### hw/spd_tick_div.sv
// Purpose: divides a stream of enable ticks by a power of two
// Assumes: shift never exceeds CNT_W
// Notes:   output tick is registered; counter restarts when disabled
`timescale 1ns/1ns
`default_nettype none
module spd_tick_div
  import spd_pkg::*;
#(
  parameter int CNT_W = 10
)(
  input  wire logic       mclk,     // system clock
  input  wire logic       srst,     // synchronous reset
  input  wire logic       en,       // counting allowed
  input  wire logic       tick_in,  // input tick
  input  wire logic [3:0] shift,    // log2 of ratio
  output logic            tick_out  // divided tick, one cycle
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (CNT_W < 1 || CNT_W > 15)
  begin : g_chk
    $error("spd_tick_div: CNT_W out of range");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } spd_div_state_type;

  spd_div_state_type s_q;
  spd_div_state_type s_d;
  logic [CNT_W-1:0]  mask;

  // terminal count for the selected ratio
  assign mask = CNT_W'((16'h0001 << shift) - 16'h0001);

  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!en)
    begin
      s_d.cnt = '0;  // restart so the first period is whole
    end
    else if (tick_in)
    begin
      if (s_q.cnt >= mask)
      begin
        s_d.cnt  = '0;
        s_d.tick = 1'b1;
      end
      else
      begin
        s_d.cnt = s_q.cnt + CNT_W'(1);
      end
    end
  end

  // state register
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign tick_out = s_q.tick;

endmodule
`default_nettype wire

// ### tb/spd_panel_model.sv
// Purpose: panel side stand-in that marks frame switches
// Assumes: same clock as the register bank
// Notes:   one registered pulse per request, never two in a row
`timescale 1ns/1ns
`default_nettype none
module spd_panel_model
(
  input  wire logic mclk,        // system clock
  input  wire logic fire,        // bench asks for a frame switch
  output logic      frame_event  // one-cycle frame pulse
);
  // registered so the pulse leaves just after an edge, like real timing logic
  always_ff @(posedge mclk)
    frame_event <= fire & ~frame_event;
endmodule
`default_nettype wire

// ### tb/tb_spd_regs.sv
// Purpose: self-checking bench for the panel driver register bank
// Assumes: apb slave answers with pready; debug input raised once, late in the run
// Notes:   expectations come from the field layout, not from reads
`timescale 1ns/1ns
`default_nettype none
module tb_spd_regs;
  import spd_pkg::*;
  logic        mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, fire = 0, frame_event, err;
  logic        pready, pslverr, irq, pin_drive_low, pin_hiz, op_tick, dbg = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int          n_errors = 0, checked = 0;
  logic [31:0] rst_v [9] = '{32'h0100, 32'h0, 32'h0307, 32'h0100, 32'h8008, 32'h0070, 32'h00ff, 32'h0, 32'h0};
  spd_regs i_spd_regs (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .debug_mode(dbg),
    .frame_event(frame_event), .source_select(), .divider_select(), .op_tick(op_tick), .boost_tick(),
    .frame_rate_setting(), .drive_duty_select(), .waveform_select(), .inverse_line_count(),
    .supply_mode_select(), .divider_resistor_select(), .contrast_level(), .booster_on(), .bias_select(),
    .heavy_load_protect(), .regulator_output_select(), .regulator_on(), .segment_order(), .common_order(),
    .display_inversion(), .display_area_select(), .display_on_off_mode(), .common_partial_drive(),
    .pin_drive_low(pin_drive_low), .pin_hiz(pin_hiz), .irq(irq));
  spd_panel_model i_spd_panel_model (.mclk(mclk), .fire(fire), .frame_event(frame_event));
  // ----------------------------------------------------------------
  // clock, bus tasks, compare
  // ----------------------------------------------------------------
  initial
    forever #2 mclk = ~mclk;
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    // wait for pready; only the watchdog ends a dead slave
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    // one idle edge so the next call never drives psel twice in a step
    psel <= 0; penable <= 0;
    @(posedge mclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin n_errors++; $display("mismatch t=%0t got %h exp %h", $time, got, exp); end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_fields();
    apb(1, OFS_TIMING_ONE, 32'hffffffff); rdc(OFS_TIMING_ONE, 32'h0f07);
    apb(1, OFS_TIMING_TWO, 32'hfffffff8); rdc(OFS_TIMING_TWO, 32'h8300);
    apb(1, OFS_TIMING_TWO, 32'h00007fff); rdc(OFS_TIMING_TWO, 32'h0307);
    apb(1, OFS_COMMON_DRIVE, 32'h0); rdc(OFS_COMMON_DRIVE, 32'h0);
    apb(1, 8'h40, 32'h1); chk({31'h0, err}, 32'h1);
  endtask
  task automatic t_clock();
    apb(1, OFS_CLOCK_CONFIG, 32'h0011); rdc(OFS_CLOCK_CONFIG, 32'h0100);
    apb(1, OFS_CLOCK_CONFIG, 32'h0071); rdc(OFS_CLOCK_CONFIG, 32'h0071);
    apb(1, OFS_CLOCK_CONFIG, 32'h0062); rdc(OFS_CLOCK_CONFIG, 32'h0062);
    apb(1, OFS_MODULE_CTRL, 32'h1); apb(1, OFS_CLOCK_CONFIG, 32'h0); rdc(OFS_CLOCK_CONFIG, 32'h0062);
  endtask
  task automatic t_disable();
    apb(1, OFS_DISPLAY_CTRL, 32'h0071); apb(1, OFS_POWER_CTRL, 32'h8001);
    apb(1, OFS_MODULE_CTRL, 32'h0); rdc(OFS_DISPLAY_CTRL, 32'h0070); rdc(OFS_POWER_CTRL, 32'h8000);
    chk({30'h0, pin_hiz, pin_drive_low}, 32'h2);
    apb(1, OFS_MODULE_CTRL, 32'h3); chk({30'h0, pin_hiz, pin_drive_low}, 32'h1);
  endtask
  task automatic t_frame();
    apb(1, OFS_IRQ_ENABLES, 32'h1);
    fire <= 1; @(posedge mclk); fire <= 0; repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    apb(1, OFS_IRQ_FLAGS, 32'h0); rdc(OFS_IRQ_FLAGS, 32'h1);
    apb(1, OFS_IRQ_FLAGS, 32'h1); rdc(OFS_IRQ_FLAGS, 32'h0); chk({31'h0, irq}, 32'h0);
  endtask
  // enabled, code 6 (1/1024), debug run 0: ticks stop in debug, then two per 2200 cycles
  task automatic t_debug();
    int n;
    n = 0;
    dbg <= 1; repeat (3) @(posedge mclk);
    repeat (1100) begin @(posedge mclk); n += op_tick; end
    chk(n, 32'h0);
    dbg <= 0; n = 0;
    repeat (2200) begin @(posedge mclk); n += op_tick; end
    chk(n, 32'h2);
  endtask
  // main sequence; reset table covers every register's initial value
  initial
  begin
    repeat (20) @(posedge mclk);
    srst <= 0;
    @(posedge mclk);
    for (int i = 0; i < 9; i++) rdc(8'(i * 4), rst_v[i]);
    t_fields();
    t_clock();
    t_disable();
    t_frame();
    t_debug();
    end_of_test();
  end
  // watchdog well beyond the roughly 3,500 cycles the sequence needs
  initial
  begin
    #40000;
    n_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
